// [hdl/ppom_top.sv]
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "ppom_regs.svh"
// Operation
// - 4-bit min single-pulse width, codes 0..15 ms, default 5.
// - second low group before window expiry raises over-current.
// - double-pulse window is 8 bits in ms, default 20 (14h).
// - sense ignored for lockout time after power turns on.
// - lockout is 8 bits in ms, default 10 (0Ah).
// - power off drives the port's pin low.
// - power on releases driver and enables pull-up, open drain.
// - low sense on powered port, fuse blown included, is over-current.
// - poly fuse uses the same one pin per port control.
// - poly-fuse mode reports power-on-to-good time zero.
// - low held for min width raises over-current.
// - two low groups within window raise over-current.
// - ganged mode flags every port on shared-pin event.
module ppom_top
	import ppom_pkg::*;
#(
	parameter int NPORTS = 6,
	parameter int TICK_CYC = `PPOM_TICK_CYC
)(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// register port
	input wire logic [15:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// port power/sense pins
	input wire logic [NPORTS-1:0] i_port_power_sense_pin,
	output logic [NPORTS-1:0] o_port_power_sense_pin,
	output logic [NPORTS-1:0] o_port_power_sense_pin_oe,
	output logic [NPORTS-1:0] o_pullup_en,
	// ganged pin
	input wire logic i_shared_power_sense_pin,
	output logic o_shared_power_sense_pin,
	output logic o_shared_power_sense_pin_oe,
	output logic o_shared_pullup_en,
	// descriptor value and interrupt
	output logic [7:0] o_pwron2pwrgood,
	output logic o_irq
);
	// elaboration-time parameter checks
	if (NPORTS < 1 || NPORTS > 7) begin : g_bad_nports
		$error("NPORTS must be 1..7");
	end
	// one-cycle tick needs a counter of two or more
	if (TICK_CYC < 2) begin : g_bad_tick
		$error("TICK_CYC must be at least 2");
	end

	logic [7:0] lockout_r;
	logic [3:0] minw_r;
	logic [7:0] window_r;
	logic [7:0] ctrl_r;
	logic [7:0] desc_r;
	logic [NPORTS-1:0] status_r;
	logic [NPORTS-1:0] irq_en_r;
	logic [31:0] tick_cnt_r;
	logic tick;
	logic gang;
	logic [NPORTS:0] chan_on;
	logic [NPORTS:0] chan_sense;
	logic [NPORTS:0] chan_low;
	logic [NPORTS:0] chan_pu;
	logic [NPORTS:0] chan_oc;
	logic [NPORTS-1:0] port_oc;

	function automatic logic hit(input logic [15:0] a,
		input logic [15:0] off);
		hit = (a == off);
	endfunction

	assign gang = ctrl_r[`PPOM_CTRL_GANG];

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n || tick)
			tick_cnt_r <= 32'h0000_0000;
		else
			tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
	end
	assign tick = (tick_cnt_r == 32'(TICK_CYC - 1));

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			lockout_r <= `PPOM_RST_LOCKOUT;
			minw_r <= `PPOM_RST_MINW;
			window_r <= `PPOM_RST_WINDOW;
			ctrl_r <= 8'h00;
			irq_en_r <= '0;
			desc_r <= 8'h00;
		end else if (i_wr) begin
			if (hit(i_addr, `PPOM_OFF_LOCKOUT))
				lockout_r <= i_wdata;
			if (hit(i_addr, `PPOM_OFF_MINW))
				minw_r <= i_wdata[`PPOM_MINW_MSB:0];
			if (hit(i_addr, `PPOM_OFF_WINDOW))
				window_r <= i_wdata;
			if (hit(i_addr, `PPOM_OFF_CTRL))
				ctrl_r <= i_wdata;
			if (hit(i_addr, `PPOM_OFF_IRQ_EN))
				irq_en_r <= i_wdata[NPORTS-1:0];
			if (hit(i_addr, `PPOM_OFF_DESC))
				desc_r <= i_wdata;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n)
			o_pwron2pwrgood <= 8'h00;
		else if (desc_r[`PPOM_DESC_POLY])
			o_pwron2pwrgood <= 8'h00;
		else
			o_pwron2pwrgood <= desc_r;
	end

	// channel NPORTS is the ganged pin
	always_comb begin
		chan_on = {1'b0, ctrl_r[NPORTS-1:0]};
		chan_sense = {i_shared_power_sense_pin, i_port_power_sense_pin};
		if (gang)
			chan_on = {|ctrl_r[NPORTS-1:0], {NPORTS{1'b0}}};
	end

	genvar g;
	generate
		for (g = 0; g <= NPORTS; g++) begin : g_chan
			ppom_port u_port (
				.i_sys_clk(i_sys_clk),
				.i_rst_n(i_rst_n),
				.i_tick(tick),
				.i_min_width(minw_r),
				.i_window(window_r),
				.i_lockout(lockout_r),
				.i_power_on(chan_on[g]),
				.i_sense(chan_sense[g]),
				.o_drive_low(chan_low[g]),
				.o_pullup_en(chan_pu[g]),
				.o_oc_event(chan_oc[g])
			);
		end
	endgenerate

	assign o_port_power_sense_pin = '0;
	assign o_port_power_sense_pin_oe = chan_low[NPORTS-1:0];
	assign o_pullup_en = chan_pu[NPORTS-1:0];
	assign o_shared_power_sense_pin = 1'b0;
	assign o_shared_power_sense_pin_oe = chan_low[NPORTS];
	assign o_shared_pullup_en = chan_pu[NPORTS];

	assign port_oc = gang ? {NPORTS{chan_oc[NPORTS]}}
		: chan_oc[NPORTS-1:0];

	// sticky status, set beats clear
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n)
			status_r <= '0;
		else if (i_wr && hit(i_addr, `PPOM_OFF_CLEAR))
			status_r <= (status_r & ~i_wdata[NPORTS-1:0]) | port_oc;
		else
			status_r <= status_r | port_oc;
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n)
			o_irq <= 1'b0;
		else
			o_irq <= |(status_r & irq_en_r);
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			o_rdata <= 8'h00;
			if (hit(i_addr, `PPOM_OFF_LOCKOUT))
				o_rdata <= lockout_r;
			if (hit(i_addr, `PPOM_OFF_MINW))
				o_rdata <= {4'h0, minw_r};
			if (hit(i_addr, `PPOM_OFF_WINDOW))
				o_rdata <= window_r;
			if (hit(i_addr, `PPOM_OFF_CTRL))
				o_rdata <= ctrl_r;
			if (hit(i_addr, `PPOM_OFF_STATUS))
				o_rdata <= 8'(status_r);
			if (hit(i_addr, `PPOM_OFF_IRQ_EN))
				o_rdata <= 8'(irq_en_r);
			if (hit(i_addr, `PPOM_OFF_PIN))
				o_rdata <= 8'(i_port_power_sense_pin);
			if (hit(i_addr, `PPOM_OFF_DESC))
				o_rdata <= desc_r;
		end else begin
			o_rdata <= 8'h00;
		end
	end

	property p_gang_all;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(gang && chan_oc[NPORTS]) |=> (&status_r);
	endproperty
	a_gang_all: assert property (p_gang_all)
		else $error("ganged event not on all ports");

	property p_irq;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(|(status_r & irq_en_r)) |=> o_irq;
	endproperty
	a_irq: assert property (p_irq)
		else $error("irq missing");

	property p_tick;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		tick |=> !tick;
	endproperty
	a_tick: assert property (p_tick)
		else $error("tick longer than one cycle");

	property p_poly;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		desc_r[`PPOM_DESC_POLY] |=> o_pwron2pwrgood == 8'h00;
	endproperty
	a_poly: assert property (p_poly)
		else $error("poly descriptor not zero");

	property p_minw;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_wr && hit(i_addr, `PPOM_OFF_MINW)) |=>
			minw_r == $past(i_wdata[3:0]);
	endproperty
	a_minw: assert property (p_minw)
		else $error("width field not stored");

	property p_lockout_wr;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_wr && hit(i_addr, `PPOM_OFF_LOCKOUT)) |=>
			lockout_r == $past(i_wdata);
	endproperty
	a_lockout_wr: assert property (p_lockout_wr)
		else $error("lockout not stored");

	property p_window_wr;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_wr && hit(i_addr, `PPOM_OFF_WINDOW)) |=>
			window_r == $past(i_wdata);
	endproperty
	a_window_wr: assert property (p_window_wr)
		else $error("window not stored");

	property p_rd_idle;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		!i_rd |=> o_rdata == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not zero when idle");

	property p_rd_minw;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_rd && hit(i_addr, `PPOM_OFF_MINW)) |=>
			o_rdata[7:4] == 4'h0;
	endproperty
	a_rd_minw: assert property (p_rd_minw)
		else $error("width upper bits not zero");

	property p_rd_status;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_rd && hit(i_addr, `PPOM_OFF_STATUS)) |=>
			o_rdata == 8'($past(status_r));
	endproperty
	a_rd_status: assert property (p_rd_status)
		else $error("status read wrong");

	property p_rd_pin;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_rd && hit(i_addr, `PPOM_OFF_PIN)) |=>
			o_rdata == 8'($past(i_port_power_sense_pin));
	endproperty
	a_rd_pin: assert property (p_rd_pin)
		else $error("pin level read wrong");

	property p_sticky;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		!(i_wr && hit(i_addr, `PPOM_OFF_CLEAR)) |=>
			(status_r & $past(status_r)) == $past(status_r);
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("status bit lost without clear");

	property p_clear;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_wr && hit(i_addr, `PPOM_OFF_CLEAR) && port_oc == '0) |=>
			(status_r & $past(i_wdata[NPORTS-1:0])) == '0;
	endproperty
	a_clear: assert property (p_clear)
		else $error("status bit not cleared");

	property p_irq_low;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(status_r & irq_en_r) == '0 |=> !o_irq;
	endproperty
	a_irq_low: assert property (p_irq_low)
		else $error("irq without enabled status");

	property p_port_pins;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		!gang |-> o_pullup_en == ctrl_r[NPORTS-1:0] &&
			o_port_power_sense_pin_oe == ~ctrl_r[NPORTS-1:0];
	endproperty
	a_port_pins: assert property (p_port_pins)
		else $error("port pins do not follow control");

	property p_gang_pins;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		gang |-> (&o_port_power_sense_pin_oe) &&
			o_shared_pullup_en == (|ctrl_r[NPORTS-1:0]);
	endproperty
	a_gang_pins: assert property (p_gang_pins)
		else $error("ganged pins wrong");

	property p_shared_off;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		!gang |-> o_shared_power_sense_pin_oe && !o_shared_pullup_en;
	endproperty
	a_shared_off: assert property (p_shared_off)
		else $error("shared pin not driven low");

	property p_tick_bound;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		tick_cnt_r < 32'(TICK_CYC);
	endproperty
	a_tick_bound: assert property (p_tick_bound)
		else $error("tick counter out of range");

	property p_desc_pass;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		!desc_r[`PPOM_DESC_POLY] |=> o_pwron2pwrgood == $past(desc_r);
	endproperty
	a_desc_pass: assert property (p_desc_pass)
		else $error("descriptor value not passed");
endmodule

// [hdl/ppom_regs.svh]
`ifndef PPOM_REGS_SVH
`define PPOM_REGS_SVH
// register byte offsets
`define PPOM_OFF_LOCKOUT 16'h30E1
`define PPOM_OFF_MINW 16'h30EA
`define PPOM_OFF_WINDOW 16'h30EB
`define PPOM_OFF_CTRL 16'h30F0
`define PPOM_OFF_STATUS 16'h30F1
`define PPOM_OFF_CLEAR 16'h30F2
`define PPOM_OFF_IRQ_EN 16'h30F3
`define PPOM_OFF_PIN 16'h30F4
`define PPOM_OFF_DESC 16'h30F5
// reset values
`define PPOM_RST_LOCKOUT 8'h0A
`define PPOM_RST_MINW 4'h5
`define PPOM_RST_WINDOW 8'h14
// field positions
`define PPOM_MINW_MSB 3
`define PPOM_CTRL_GANG 7
`define PPOM_DESC_POLY 0
// timing
`define PPOM_CLK_HZ 25000000
`define PPOM_TICK_MS 1
`define PPOM_TICK_CYC (`PPOM_CLK_HZ / 1000 * `PPOM_TICK_MS)
`endif

// [hdl/ppom_pkg.sv]
package ppom_pkg;
	typedef enum logic [3:0] {
		PPOM_OFF = 4'b0001,
		PPOM_LOCK = 4'b0010,
		PPOM_ARMED = 4'b0100,
		PPOM_FAULT = 4'b1000
	} ppom_state_t;
endpackage

// [hdl/ppom_port.sv]
`timescale 1ns/1ps
`include "ppom_regs.svh"
module ppom_port
	import ppom_pkg::*;
(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// timing
	input wire logic i_tick,
	input wire logic [3:0] i_min_width,
	input wire logic [7:0] i_window,
	input wire logic [7:0] i_lockout,
	// control and pin
	input wire logic i_power_on,
	input wire logic i_sense,
	output logic o_drive_low,
	output logic o_pullup_en,
	output logic o_oc_event
);
	ppom_state_t st_r;
	logic [3:0] low_ms_r;
	logic [7:0] win_ms_r;
	logic [7:0] lock_ms_r;
	logic win_act_r;
	logic in_low_r;
	logic sense_low;
	logic single_hit;
	logic group_start;
	logic oc;

	assign sense_low = (st_r == PPOM_ARMED) && !i_sense;
	assign group_start = sense_low && !in_low_r;
	assign single_hit = sense_low &&
		((i_min_width == 4'h0) || (low_ms_r >= i_min_width));
	assign oc = single_hit || (group_start && win_act_r);

	assign o_drive_low = !i_power_on;
	assign o_pullup_en = i_power_on;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			st_r <= PPOM_OFF;
		end else if (!i_power_on) begin
			st_r <= PPOM_OFF;
		end else begin
			unique case (st_r)
				PPOM_OFF: st_r <= PPOM_LOCK;
				PPOM_LOCK: if (i_tick && lock_ms_r <= 8'h01)
					st_r <= PPOM_ARMED;
				PPOM_ARMED: if (oc)
					st_r <= PPOM_FAULT;
				PPOM_FAULT: st_r <= PPOM_FAULT;
				default: st_r <= PPOM_OFF;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n)
			lock_ms_r <= 8'h00;
		else if (st_r != PPOM_LOCK)
			lock_ms_r <= i_lockout;
		else if (i_tick && lock_ms_r != 8'h00)
			lock_ms_r <= lock_ms_r - 8'h01;
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			low_ms_r <= 4'h0;
			in_low_r <= 1'b0;
		end else begin
			in_low_r <= sense_low;
			if (!sense_low)
				low_ms_r <= 4'h0;
			else if (i_tick && low_ms_r != 4'hF)
				low_ms_r <= low_ms_r + 4'h1;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n || st_r != PPOM_ARMED) begin
			win_act_r <= 1'b0;
			win_ms_r <= 8'h00;
		end else if (group_start) begin
			win_act_r <= 1'b1;
			win_ms_r <= i_window;
		end else if (win_act_r && i_tick && !sense_low) begin
			win_ms_r <= win_ms_r - 8'h01;
			if (win_ms_r <= 8'h01)
				win_act_r <= 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n)
			o_oc_event <= 1'b0;
		else
			o_oc_event <= oc && (st_r == PPOM_ARMED);
	end

	property p_lock_quiet;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(st_r == PPOM_LOCK) |=> !o_oc_event;
	endproperty
	a_lock_quiet: assert property (p_lock_quiet)
		else $error("event during lockout");

	property p_off_drive;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		!i_power_on |-> o_drive_low && !o_pullup_en;
	endproperty
	a_off_drive: assert property (p_off_drive)
		else $error("pin not driven low when off");

	property p_on_release;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_power_on |-> !o_drive_low && o_pullup_en;
	endproperty
	a_on_release: assert property (p_on_release)
		else $error("pin not released when on");

	property p_single;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(st_r == PPOM_ARMED && single_hit) |=> o_oc_event;
	endproperty
	a_single: assert property (p_single)
		else $error("single pulse missed");

	sequence s_second_group;
		st_r == PPOM_ARMED && group_start && win_act_r && i_power_on;
	endsequence
	property p_double;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		s_second_group |=> o_oc_event && (st_r == PPOM_FAULT);
	endproperty
	a_double: assert property (p_double)
		else $error("double pulse missed");

	property p_win_load;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(st_r == PPOM_ARMED && group_start && i_power_on) |=>
			win_act_r && win_ms_r == $past(i_window);
	endproperty
	a_win_load: assert property (p_win_load)
		else $error("window not loaded");

	property p_cause;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		o_oc_event |-> $past(st_r) == PPOM_ARMED && !$past(i_sense);
	endproperty
	a_cause: assert property (p_cause)
		else $error("event without low sense");
endmodule

// [sim/ppom_switch_model.sv]
`timescale 1ns/1ps
module ppom_switch_model #(
	parameter int N = 1
)(
	// pin drive from the hub
	input wire logic [N-1:0] i_drive,
	input wire logic [N-1:0] i_drive_oe,
	input wire logic [N-1:0] i_pullup_en,
	// fault command from the bench
	input wire logic [N-1:0] i_fault,
	// resolved pin level
	output logic [N-1:0] o_pin
);
	always_comb begin
		for (int k = 0; k < N; k++) begin
			if (i_drive_oe[k])
				o_pin[k] = i_drive[k];
			else if (i_fault[k])
				o_pin[k] = 1'b0;
			else
				o_pin[k] = i_pullup_en[k];
		end
	end
endmodule

// [sim/ppom_top_bench.sv]
`timescale 1ns/1ps
`include "ppom_regs.svh"
module ppom_top_bench;
	import ppom_pkg::*;
	logic i_sys_clk, i_rst_n, i_wr, i_rd, irq;
	logic [15:0] i_addr;
	logic [7:0] i_wdata, rdata, p2g;
	logic [1:0] pin, drv, oe, pu;
	logic spin, sdrv, soe, spu;
	logic [2:0] fault;
	int miscompares, tests_run;

	ppom_top #(.NPORTS(2), .TICK_CYC(10)) uut (
		.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(rdata), .i_port_power_sense_pin(pin),
		.o_port_power_sense_pin(drv), .o_port_power_sense_pin_oe(oe),
		.o_pullup_en(pu), .i_shared_power_sense_pin(spin),
		.o_shared_power_sense_pin(sdrv),
		.o_shared_power_sense_pin_oe(soe), .o_shared_pullup_en(spu),
		.o_pwron2pwrgood(p2g), .o_irq(irq));
	ppom_switch_model #(.N(2)) sw_ports (.i_drive(drv),
		.i_drive_oe(oe), .i_pullup_en(pu), .i_fault(fault[1:0]),
		.o_pin(pin));
	ppom_switch_model #(.N(1)) sw_shared (.i_drive(sdrv),
		.i_drive_oe(soe), .i_pullup_en(spu), .i_fault(fault[2]),
		.o_pin(spin));

	initial begin
		i_sys_clk = 1'b0;
		forever #20 i_sys_clk = ~i_sys_clk;
	end

	task automatic results();
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge i_sys_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		@(negedge i_sys_clk);
		chk(rdata, exp);
	endtask

	task automatic pulse(input int k, input int n);
		@(posedge i_sys_clk);
		fault[k] <= 1'b1;
		repeat (n) @(posedge i_sys_clk);
		fault[k] <= 1'b0;
	endtask

	task automatic wait_irq(input int n);
		for (int i = 0; i < n && irq !== 1'b1; i++)
			@(posedge i_sys_clk);
		if (irq !== 1'b1) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, irq, 1'b1);
			results();
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge i_sys_clk);
	endtask

	initial begin
		i_rst_n = 1'b0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 16'h0000;
		i_wdata = 8'h00;
		fault = 3'h0;
		miscompares = 0;
		tests_run = 0;
		idle(4);
		i_rst_n <= 1'b1;
		@(negedge i_sys_clk);
		chk({4'h0, pu, oe}, 8'h03);
		chk({6'h00, spu, soe}, 8'h01);
		chk({5'h00, sdrv, drv}, 8'h00);
		rd(`PPOM_OFF_LOCKOUT, 8'h0A);
		rd(`PPOM_OFF_MINW, 8'h05);
		rd(`PPOM_OFF_WINDOW, 8'h14);
		rd(16'h30E0, 8'h00);
		wr(`PPOM_OFF_LOCKOUT, 8'h05);
		rd(`PPOM_OFF_LOCKOUT, 8'h05);
		wr(`PPOM_OFF_LOCKOUT, 8'h0A);
		wr(`PPOM_OFF_MINW, 8'hF3);
		rd(`PPOM_OFF_MINW, 8'h03);
		wr(`PPOM_OFF_MINW, 8'h02);
		wr(`PPOM_OFF_IRQ_EN, 8'hFF);
		wr(`PPOM_OFF_WINDOW, 8'h02);
		wr(`PPOM_OFF_CTRL, 8'h01);
		idle(1);
		@(negedge i_sys_clk);
		chk({4'h0, pu, oe}, 8'h06);
		rd(`PPOM_OFF_PIN, 8'h01);
		pulse(0, 60);
		idle(80);
		rd(`PPOM_OFF_STATUS, 8'h00);
		@(posedge i_sys_clk);
		fault[0] <= 1'b1;
		wait_irq(60);
		rd(`PPOM_OFF_PIN, 8'h00);
		fault[0] <= 1'b0;
		rd(`PPOM_OFF_STATUS, 8'h01);
		wr(`PPOM_OFF_IRQ_EN, 8'h00);
		idle(3);
		chk({7'h00, irq}, 8'h00);
		wr(`PPOM_OFF_CTRL, 8'h00);
		wr(`PPOM_OFF_CLEAR, 8'h01);
		rd(`PPOM_OFF_STATUS, 8'h00);
		wr(`PPOM_OFF_IRQ_EN, 8'hFF);
		// short pulses, each spans at most one tick
		wr(`PPOM_OFF_MINW, 8'h05);
		wr(`PPOM_OFF_CTRL, 8'h02);
		idle(130);
		pulse(1, 5);
		idle(60);
		pulse(1, 5);
		idle(40);
		rd(`PPOM_OFF_STATUS, 8'h00);
		wr(`PPOM_OFF_WINDOW, 8'h14);
		pulse(1, 5);
		idle(30);
		pulse(1, 5);
		wait_irq(40);
		rd(`PPOM_OFF_STATUS, 8'h02);
		wr(`PPOM_OFF_CTRL, 8'h00);
		wr(`PPOM_OFF_CLEAR, 8'h03);
		wr(`PPOM_OFF_CTRL, 8'h81);
		idle(1);
		@(negedge i_sys_clk);
		chk({4'h0, spu, soe, oe}, 8'h0B);
		idle(130);
		@(posedge i_sys_clk);
		fault[2] <= 1'b1;
		wait_irq(90);
		fault[2] <= 1'b0;
		rd(`PPOM_OFF_STATUS, 8'h03);
		wr(`PPOM_OFF_CTRL, 8'h00);
		wr(`PPOM_OFF_DESC, 8'h64);
		idle(2);
		chk(p2g, 8'h64);
		wr(`PPOM_OFF_DESC, 8'h65);
		idle(2);
		chk(p2g, 8'h00);
		results();
	end
endmodule
